/* File: rtl/rcd_pkg.sv */
package rcd_pkg;
    localparam int NUM_CH                = 8;
    localparam int FRAME_BITS            = 16;
    localparam int CLK_PERIOD_NS         = 4;
    localparam int DIAG_FILTER_US        = 30;
    localparam int OVL_DELAY_US          = 11;
    localparam int OT_FILTER_US          = 1;
    localparam int DIAG_FILTER_CYC       = (DIAG_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OVL_DELAY_CYC         = (OVL_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OT_FILTER_CYC         = (OT_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W                 = 14;
    localparam int BITCNT_W              = 8;
    localparam logic [15:0] CMD_RESET    = 16'hFFFF;
    localparam logic [15:0] DIAG_RESET   = 16'hFFFF;
    localparam logic [1:0] CMD_CLEAR     = 2'h0;
    localparam logic [1:0] CMD_INPUT     = 2'h1;
    localparam logic [1:0] CMD_ON        = 2'h2;
    localparam logic [1:0] CMD_OFF       = 2'h3;
    // Two-bit diagnosis codes per channel
    localparam logic [1:0] DIAG_OVERLOAD = 2'h0;
    localparam logic [1:0] DIAG_GND      = 2'h1;
    localparam logic [1:0] DIAG_OPEN     = 2'h2;
    localparam logic [1:0] DIAG_NONE     = 2'h3;
    typedef enum logic [3:0] {
        RCD_NORMAL  = 4'b0001,
        RCD_OT_HOLD = 4'b0010,
        RCD_LOCKED  = 4'b0100,
        RCD_CLEARED = 4'b1000
    } rcd_state_t;
endpackage : rcd_pkg

/* File: rtl/rcd_channel.sv */
`timescale 1ns/100ps
module rcd_channel
    import rcd_pkg::*;
#(
    parameter int DIAG_FILT = DIAG_FILTER_CYC,
    parameter int OVL_DLY   = OVL_DELAY_CYC,
    parameter int OT_FILT   = OT_FILTER_CYC
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Control
    input  wire logic [1:0]       cmd,
    input  wire logic             in_pin,
    // Comparators and sensors, already synchronised
    input  wire logic             below_gnd,
    input  wire logic             below_open,
    input  wire logic             overtemp,
    input  wire logic             clamping,
    input  wire logic             overload,
    // Results
    output logic                  gate_on,
    output logic                  diag_current_en,
    output logic [1:0]            diag_code
);
    rcd_state_t       state_reg, state_next;
    logic [1:0]       code_reg, code_next;
    logic [CNT_W-1:0] gnd_cnt_reg, gnd_cnt_next;
    logic [CNT_W-1:0] open_cnt_reg, open_cnt_next;
    logic [CNT_W-1:0] ovl_cnt_reg, ovl_cnt_next;
    logic [CNT_W-1:0] ot_cnt_reg, ot_cnt_next;
    logic             want_on, locked, is_on, is_off_diag;
    logic             gnd_cond, open_cond, ot_cond;
    logic             gnd_hit, open_hit, ovl_hit, ot_hit;

    function automatic logic [CNT_W-1:0] filt_step(input logic cond, input logic [CNT_W-1:0] cnt, input int lim);
        if (!cond) begin
            filt_step = '0;
        end else if (cnt < CNT_W'(lim)) begin
            filt_step = cnt + CNT_W'(1);
        end else begin
            filt_step = cnt;
        end
    endfunction : filt_step

    always_comb begin
        want_on     = (cmd == CMD_ON) || (cmd == CMD_INPUT && in_pin);
        locked      = (state_reg == RCD_LOCKED) || (state_reg == RCD_OT_HOLD);
        is_on       = want_on && !locked;
        // Off diagnosis only in OFF or input-low, never in clear
        is_off_diag = (cmd == CMD_OFF) || (cmd == CMD_INPUT && !in_pin);
        // below ground threshold is short, between is open
        gnd_cond    = is_off_diag && below_gnd;
        open_cond   = is_off_diag && !below_gnd && below_open;
        // counted only when on or clamping
        ot_cond     = overtemp && (is_on || clamping) && cmd != CMD_CLEAR;
        gnd_cnt_next  = filt_step(gnd_cond, gnd_cnt_reg, DIAG_FILT);
        open_cnt_next = filt_step(open_cond, open_cnt_reg, DIAG_FILT);
        ovl_cnt_next  = filt_step(overload && is_on, ovl_cnt_reg, OVL_DLY);
        ot_cnt_next   = filt_step(ot_cond, ot_cnt_reg, OT_FILT);
        gnd_hit  = gnd_cnt_reg == CNT_W'(DIAG_FILT);
        open_hit = open_cnt_reg == CNT_W'(DIAG_FILT);
        ovl_hit  = ovl_cnt_reg == CNT_W'(OVL_DLY);
        ot_hit   = ot_cnt_reg == CNT_W'(OT_FILT);
        code_next  = code_reg;
        state_next = state_reg;
        if (cmd == CMD_CLEAR) begin
            code_next = DIAG_NONE;
            if (!overtemp && !clamping) begin
                state_next = RCD_CLEARED;
            end
        end else begin
            // Leave the cleared state first so a fault in the same cycle still locks
            if (state_reg == RCD_CLEARED) begin
                state_next = RCD_NORMAL;
            end
            if (ovl_hit) begin
                code_next  = DIAG_OVERLOAD;
                state_next = RCD_LOCKED;
            end else if (ot_hit) begin
                state_next = RCD_OT_HOLD;
            end else if (code_reg != DIAG_OVERLOAD) begin
                if (gnd_hit) begin
                    code_next = DIAG_GND;
                end else if (open_hit && code_reg != DIAG_GND) begin
                    code_next = DIAG_OPEN;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg    <= RCD_NORMAL;
            code_reg     <= DIAG_NONE;
            gnd_cnt_reg  <= '0;
            open_cnt_reg <= '0;
            ovl_cnt_reg  <= '0;
            ot_cnt_reg   <= '0;
        end else begin
            state_reg    <= state_next;
            code_reg     <= code_next;
            gnd_cnt_reg  <= gnd_cnt_next;
            open_cnt_reg <= open_cnt_next;
            ovl_cnt_reg  <= ovl_cnt_next;
            ot_cnt_reg   <= ot_cnt_next;
        end
    end

    // unclamped off overtemp term never blocks: while is_on, ot_cond is set whenever overtemp is
    assign gate_on         = is_on && !(overtemp && state_reg == RCD_NORMAL && !ot_cond) && !ovl_hit && !ot_hit;
    assign diag_current_en = cmd != CMD_CLEAR && !want_on;
    assign diag_code       = code_reg;
endmodule : rcd_channel

/* File: rtl/rcd_top.sv */
`timescale 1ns/100ps
module rcd_top
    import rcd_pkg::*;
#(
    parameter int DIAG_FILT = DIAG_FILTER_CYC,
    parameter int OVL_DLY   = OVL_DELAY_CYC,
    parameter int OT_FILT   = OT_FILTER_CYC
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // Serial port pins
    input  wire logic              cs_n,
    input  wire logic              sclk,
    input  wire logic              sdi,
    output logic                   sdo,
    output logic                   sdo_oe,
    // Channel pins and analog status
    input  wire logic [NUM_CH-1:0] in_pins,
    input  wire logic [NUM_CH-1:0] below_gnd,
    input  wire logic [NUM_CH-1:0] below_open,
    input  wire logic [NUM_CH-1:0] overtemp,
    input  wire logic [NUM_CH-1:0] clamping,
    input  wire logic [NUM_CH-1:0] overload,
    // Channel outputs and standby flag
    output logic [NUM_CH-1:0]      gate_on,
    output logic [NUM_CH-1:0]      diag_current_en,
    output logic                   standby
);
    import rcd_pkg::*;
    localparam int SW = 3 + 6 * NUM_CH;
    logic [SW-1:0]       s1_reg, s2_reg, s3_reg;
    logic                cs_n_s, sclk_s, sdi_s, cs_n_d, sclk_d;
    logic [SW-1:0]       pin_vec;
    logic [15:0]         cmd_reg, cmd_next;
    logic [15:0]         rx_reg, rx_next;
    logic [16:0]         tx_reg, tx_next;
    logic [BITCNT_W-1:0] bits_reg, bits_next;
    logic                ter_reg, ter_next;
    logic                sdo_reg, sdo_next;
    logic                cs_fall, cs_rise, sclk_fall, sclk_rise;
    logic [15:0]         diag_vec;
    logic [NUM_CH-1:0]   g_on;

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers, third stage for edge detection
    assign pin_vec = {cs_n, sclk, sdi, in_pins, below_gnd, below_open, overtemp, clamping, overload};
    always_ff @(posedge clk) begin
        if (!nrst) begin
            // Idle levels: deselected, link clock low, so no false edge after reset
            s1_reg <= {3'h4, {(SW-3){1'b0}}};
            s2_reg <= {3'h4, {(SW-3){1'b0}}};
            s3_reg <= {3'h4, {(SW-3){1'b0}}};
        end else begin
            s1_reg <= pin_vec;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    assign cs_n_s    = s2_reg[SW-1];
    assign sclk_s    = s2_reg[SW-2];
    assign sdi_s     = s2_reg[SW-3];
    assign cs_n_d    = s3_reg[SW-1];
    assign sclk_d    = s3_reg[SW-2];
    assign cs_fall   = cs_n_d && !cs_n_s;
    assign cs_rise   = !cs_n_d && cs_n_s;
    assign sclk_fall = !cs_n_s && sclk_d && !sclk_s;
    assign sclk_rise = !cs_n_s && !sclk_d && sclk_s;

    ////////////////////////////////////////////////////////////////////////////
    // Channels
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        rcd_channel #(
            .DIAG_FILT (DIAG_FILT),
            .OVL_DLY   (OVL_DLY),
            .OT_FILT   (OT_FILT)
        ) u_ch (
            .clk             (clk),
            .nrst            (nrst),
            .cmd             (cmd_reg[2*i+1:2*i]),
            .in_pin          (s2_reg[5*NUM_CH+i]),
            .below_gnd       (s2_reg[4*NUM_CH+i]),
            .below_open      (s2_reg[3*NUM_CH+i]),
            .overtemp        (s2_reg[2*NUM_CH+i]),
            .clamping        (s2_reg[NUM_CH+i]),
            .overload        (s2_reg[i]),
            .gate_on         (g_on[i]),
            .diag_current_en (diag_current_en[i]),
            .diag_code       (diag_vec[2*i+1:2*i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial slave
    always_comb begin
        cmd_next  = cmd_reg;
        rx_next   = rx_reg;
        tx_next   = tx_reg;
        bits_next = bits_reg;
        ter_next  = ter_reg;
        sdo_next  = sdo_reg;
        if (cs_fall) begin
            tx_next   = {ter_reg, diag_vec};
            bits_next = '0;
            sdo_next  = ter_reg | sdi_s;
        end else if (sclk_rise) begin
            sdo_next = bits_reg == '0 ? tx_reg[15] : tx_reg[14];
            if (bits_reg != '0) begin
                tx_next = {tx_reg[16], tx_reg[14:0], rx_reg[15]};
            end
        end else if (sclk_fall) begin
            rx_next = {rx_reg[14:0], sdi_s};
            if (bits_reg != '1) begin
                bits_next = bits_reg + BITCNT_W'(1);
            end
        end else if (cs_rise) begin
            if (bits_reg[2:0] == 3'h0 && bits_reg >= BITCNT_W'(FRAME_BITS)) begin
                cmd_next = rx_reg;
                ter_next = 1'b0;
            end
        end
        if (cmd_reg == 16'h0000 && cs_n_s && !cs_rise) begin
            // Standby defaults only between frames, so a frame can still leave standby
            rx_next = 16'h0000;
            tx_next = {ter_reg, DIAG_RESET};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmd_reg  <= CMD_RESET;
            rx_reg   <= '0;
            tx_reg   <= '0;
            bits_reg <= '0;
            ter_reg  <= 1'b1;
            sdo_reg  <= 1'b0;
        end else begin
            cmd_reg  <= cmd_next;
            rx_reg   <= rx_next;
            tx_reg   <= tx_next;
            bits_reg <= bits_next;
            ter_reg  <= ter_next;
            sdo_reg  <= sdo_next;
        end
    end

    assign sdo     = sdo_reg;
    assign sdo_oe  = !cs_n_s;
    assign gate_on = g_on;
    assign standby = cmd_reg == 16'h0000;
endmodule : rcd_top

/* File: tb/rcd_sva.sv */
`timescale 1ns/100ps
module rcd_sva
    import rcd_pkg::*;
#(
    parameter int OVL_DLY = OVL_DELAY_CYC
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              nrst,
    // Serial port
    input wire logic              cs_n,
    input wire logic              sdo_oe,
    // Channels and standby
    input wire logic [NUM_CH-1:0] overload,
    input wire logic [NUM_CH-1:0] overtemp,
    input wire logic [NUM_CH-1:0] gate_on,
    input wire logic [NUM_CH-1:0] diag_current_en,
    input wire logic              standby
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Consecutive overload cycles on channel 0
    logic [7:0] ocnt_reg;
    logic [7:0] ocnt_next;
    always_comb begin
        ocnt_next = overload[0] ? ocnt_reg + {7'h00, ocnt_reg != 8'hFF} : 8'h00;
    end
    always_ff @(posedge clk) begin
        ocnt_reg <= nrst ? ocnt_next : 8'h00;
    end
    sequence cs_idle; cs_n [*5]; endsequence
    sequence cs_held; !cs_n [*5]; endsequence
    sequence ovl_hit; $fell(gate_on[0]) && overload[0]; endsequence
    sequence ot_on; $rose(overtemp[7]) && gate_on[7] ##1 overtemp[7] [*8]; endsequence
    oe_idle_a: assert property (cs_idle |-> !sdo_oe)
        else $error("sdo_oe high while deselected");
    oe_sel_a: assert property (cs_held |-> sdo_oe)
        else $error("sdo_oe low while selected");
    clr_current_a: assert property (standby |-> diag_current_en == 8'h00)
        else $error("diagnosis currents on in clear mode");
    clr_gate_a: assert property (standby |-> gate_on == 8'h00)
        else $error("gate on in clear mode");
    ovl_delay_a: assert property (ovl_hit |-> ocnt_reg >= OVL_DLY - 1)
        else $error("overload shutdown too early");
    ovl_lock_a: assert property (ovl_hit |=> !gate_on[0] [*8])
        else $error("overload lockout released");
    ovl_filt_a: assert property ($rose(overload[0]) && gate_on[0] |-> gate_on[0] [*4])
        else $error("overload acted before filtering");
    ot_off_a: assert property (ot_on |-> ##[0:4] !gate_on[7])
        else $error("overtemperature did not switch off");
endmodule : rcd_sva
bind rcd_top rcd_sva #(.OVL_DLY(OVL_DLY)) rcd_sva_i (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sdo_oe(sdo_oe),
    .overload(overload), .overtemp(overtemp), .gate_on(gate_on), .diag_current_en(diag_current_en),
    .standby(standby));

/* File: tb/rcd_host.sv */
`timescale 1ns/100ps
module rcd_host (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic     cs_n,
    output logic     sclk,
    output logic     sdi,
    input wire logic sdo
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi  = 1'b0;
    end
    // Half period of the 80 ns link clock
    task automatic hp;
        repeat (10) @(posedge clk);
        #1;
    endtask : hp
    // Frame sent MSB first; link clock stands low outside frames
    task automatic xfer(input logic [31:0] d, input int n, output logic [31:0] rx, output logic ter);
        rx   = 32'h0000_0000;
        cs_n = 1'b0;
        sdi  = 1'b0;
        hp();
        ter = sdo;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b1;
            sdi  = d[i];
            hp();
            rx   = {rx[30:0], sdo};
            sclk = 1'b0;
            hp();
        end
        cs_n = 1'b1;
        sdi  = ~sdi;
        hp();
    endtask : xfer
endmodule : rcd_host

/* File: tb/tb_rcd_top.sv */
`timescale 1ns/100ps
module tb_rcd_top;
    import rcd_pkg::*;
    localparam int FILT = 8;
    logic              clk, nrst, cs_n, sclk, sdi, sdo, sdo_oe, standby, ter;
    logic [NUM_CH-1:0] in_pins, below_gnd, below_open, overtemp, clamping, overload, gate_on, diag_current_en;
    logic [31:0]       rx;
    int                failures, tests_run;
    rcd_top #(.DIAG_FILT(FILT), .OVL_DLY(FILT), .OT_FILT(FILT)) rcd_top_i (.clk(clk), .nrst(nrst),
        .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .in_pins(in_pins),
        .below_gnd(below_gnd), .below_open(below_open), .overtemp(overtemp), .clamping(clamping),
        .overload(overload), .gate_on(gate_on), .diag_current_en(diag_current_en), .standby(standby));
    rcd_host rcd_host_i (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic send(input logic [15:0] c);
        rcd_host_i.xfer({16'h0000, c}, 16, rx, ter);
    endtask : send
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check("gate after reset", gate_on, 8'h00);
        send(16'h0000);
        check("ter", ter, 1'b1);
        check("diag reset", rx[15:0], DIAG_RESET);
        check("standby", standby, 1'b1);
        check("currents", diag_current_en, 8'h00);
        send(16'hFFFF);
        check("standby off", standby, 1'b0);
    endtask : t_reset
    task automatic t_length;
        int lens[3] = '{8, 15, 17};
        foreach (lens[i]) begin
            rcd_host_i.xfer(32'hAAAA_AAAA, lens[i], rx, ter);
            if (i == 0) check("ter cleared", ter, 1'b0);
            check("refused", gate_on, 8'h00);
        end
        rcd_host_i.xfer(32'h00AA_FFFE, 24, rx, ter);
        check("24 bits", gate_on, 8'h01);
    endtask : t_length
    task automatic t_overload;
        send(16'hFFF6);
        in_pins[1] = 1'b1;
        cyc(4);
        check("gate modes", gate_on, 8'h03);
        check("currents modes", diag_current_en, 8'hFC);
        overload[0] = 1'b1;
        cyc(FILT - 3);
        overload[0] = 1'b0;
        cyc(2);
        check("short overload", gate_on, 8'h03);
        overload[0] = 1'b1;
        cyc(FILT + 6);
        overload[0] = 1'b0;
        check("overload off", gate_on, 8'h02);
        send(16'hFFF7);
        {below_gnd[0], below_open[0]} = 2'b11;
        cyc(FILT + 6);
        send(16'hFFF6);
        check("overload kept", rx[1:0], DIAG_OVERLOAD);
        check("locked", gate_on, 8'h02);
        {below_gnd[0], below_open[0]} = 2'b00;
        send(16'hFFF4);
        send(16'hFFF6);
        check("reopened", gate_on, 8'h03);
    endtask : t_overload
    task automatic t_offdiag;
        {below_gnd[2], below_open[2], below_open[3]} = 3'b111;
        {in_pins[1], below_open[1]} = 2'b01;
        cyc(FILT + 6);
        check("input low currents", diag_current_en[1], 1'b1);
        send(16'hFFE6);
        check("off diag", rx[15:0], 16'hFF9B);
        {below_gnd[2], below_open[2], below_open[1]} = 3'b000;
        overload[2] = 1'b1;
        cyc(FILT + 6);
        overload[2] = 1'b0;
        send(16'hFFE6);
        check("overload replaces", rx[5:4], DIAG_OVERLOAD);
    endtask : t_offdiag
    task automatic t_overtemp;
        send(16'h0000);
        send(16'hBFFF);
        overtemp[7:5] = 3'b111;
        clamping[6]   = 1'b1;
        cyc(FILT + 8);
        {overtemp[7:5], clamping[6]} = 4'h0;
        cyc(4);
        check("hot off", gate_on, 8'h00);
        send(16'hABFF);
        check("hot relock", gate_on, 8'h20);
        send(16'h0BFF);
        send(16'hABFF);
        check("hot cleared", gate_on, 8'hE0);
    endtask : t_overtemp
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #100000;
        failures++;
        give_verdict();
    end
    initial begin
        nrst      = 1'b0;
        failures  = 0;
        tests_run = 0;
        {in_pins, below_gnd, below_open, overtemp, clamping, overload} = '0;
        cyc(10);
        nrst = 1'b1;
        cyc(3);
        t_reset();
        t_length();
        t_overload();
        t_offdiag();
        t_overtemp();
        give_verdict();
    end
endmodule : tb_rcd_top
